// ---- bench/ofc_cpu_model.sv ----
// Purpose: processor-side bus master driving the flash controller registers
// Assumes: one-cycle strobes, read data valid only in the cycle after the strobe
// Notes:   idle address and data lines show inverted last values
`include "ofc_consts.svh"
module ofc_cpu_model (
    input  wire logic        ref_clk,  // system clock
    output logic      [7:0]  regAddr,  // register byte address
    output logic      [31:0] regWdata, // write data
    output logic             regWr,    // write strobe
    output logic             regRd,    // read strobe
    input  wire logic [31:0] regRdata  // read data
);
    initial begin
        regAddr  = 8'h00;
        regWdata = 32'h0000_0000;
        regWr    = 1'b0;
        regRd    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        regAddr <= ~a;
        @(negedge ref_clk);
        d = regRdata;
    endtask

    // one aligned 32-bit word per command
    task automatic op(input logic [1:0] c, input logic [15:0] fa, input logic [31:0] d);
        wr(`OFC_REG_ADDR, {16'h0000, fa[15:2], 2'b00});
        wr(`OFC_REG_DATA, d);
        wr(`OFC_REG_CMD, {30'h0, c});
    endtask

    task automatic wait_idle(output logic [31:0] s);
        s = 32'h0000_0001;
        for (int i = 0; i < 4000 && s[`OFC_STAT_BUSY] !== 1'b0; i++) begin
            rd(`OFC_REG_STAT, s);
        end
    endtask

    task automatic peek(input logic [15:0] fa, output logic [31:0] d);
        wr(`OFC_REG_ADDR, {16'h0000, fa});
        rd(`OFC_REG_DATA, d);
    endtask
endmodule

// ---- bench/test_onchip_flash_controller.sv ----
// Purpose: self-checking bench for the on-chip flash controller
// Assumes: clocks-per-microsecond set to 1 or 3 to keep pulses short
// Notes:   array is erased before any unmasked read since it is not reset
`include "ofc_consts.svh"
module test_onchip_flash_controller;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] fa;
        logic [31:0] d;
        logic [31:0] e;
    } ofc_row_t;

    logic        ref_clk;
    logic        reset_n;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        flashIrq;
    logic        busy;
    logic [31:0] v;
    logic [31:0] s;
    int          errorCnt;
    int          cmpCount;
    int          cycles;
    int          busyLen;
    int          b0;

    // each word programmed once after its block erase
    ofc_row_t rows [5] = '{
        '{16'h0000, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
        '{16'h0100, 32'hffff_00ff, 32'hffff_00ff},
        '{16'h03fc, 32'h1234_5678, 32'h1234_5678},
        '{16'h0404, 32'h0f0f_0f0f, 32'h0f0f_0f0f},
        '{16'h07fc, 32'h8000_0001, 32'h8000_0001}};
    logic [7:0]  rstA [6] = '{`OFC_REG_USEC, `OFC_REG_PROT, `OFC_REG_RIS,
                              `OFC_REG_IMASK, `OFC_REG_STAT, 8'h28};
    logic [31:0] rstV [6] = '{{24'h0, `OFC_USEC_RESET}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    onchip_flash_controller onchip_flash_controller_inst (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .regWr    (regWr),
        .regRd    (regRd),
        .regRdata (regRdata),
        .flashIrq (flashIrq),
        .busy     (busy)
    );

    ofc_cpu_model ofc_cpu_model_inst (
        .ref_clk  (ref_clk),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .regWr    (regWr),
        .regRd    (regRd),
        .regRdata (regRdata)
    );

    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (busy === 1'b1) busyLen++;
        if (cycles == 40000) begin
            errorCnt++;
            finalReport();
        end
    end

    task automatic finalReport;
        if (errorCnt == 0 && cmpCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ofc_cpu_model_inst.rd(a, d);
        chk(d, exp);
    endtask

    task automatic resetChk;
        chk({30'h0, busy, flashIrq}, 32'h0);
        foreach (rstA[i]) rdchk(rstA[i], rstV[i]);
    endtask

    initial begin
        ref_clk  = 1'b0;
        reset_n  = 1'b0;
        errorCnt = 0;
        cmpCount = 0;
        cycles   = 0;
        busyLen  = 0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        resetChk();
        ofc_cpu_model_inst.wr(`OFC_REG_USEC, 32'h1);
        ofc_cpu_model_inst.wr(`OFC_REG_IMASK, 32'h3);
        for (int b = 0; b < 3; b++) begin
            ofc_cpu_model_inst.op(`OFC_CMD_ERASE, 16'(b * 1024), 32'h0);
            ofc_cpu_model_inst.wait_idle(s);
        end
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h3);
        foreach (rows[i]) begin
            ofc_cpu_model_inst.op(`OFC_CMD_PROG, rows[i].fa, rows[i].d);
            ofc_cpu_model_inst.wait_idle(s);
            chk(s, 32'h0);
            rdchk(`OFC_REG_RIS, 32'h1);
            chk({31'h0, flashIrq}, 32'h1);
            ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h1);
            ofc_cpu_model_inst.peek(rows[i].fa, v);
            chk(v, rows[i].e);
            chk({31'h0, flashIrq}, 32'h0);
        end
        // erase with a program attempted while busy
        ofc_cpu_model_inst.op(`OFC_CMD_ERASE, 16'h0400, 32'h0);
        ofc_cpu_model_inst.op(`OFC_CMD_PROG, 16'h0004, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        ofc_cpu_model_inst.peek(16'h0404, v);
        chk(v, `OFC_ERASED_WORD);
        ofc_cpu_model_inst.peek(16'h07fc, v);
        chk(v, `OFC_ERASED_WORD);
        ofc_cpu_model_inst.peek(16'h0000, v);
        chk(v, 32'ha5a5_5a5a);
        ofc_cpu_model_inst.peek(16'h0004, v);
        chk(v, `OFC_ERASED_WORD);
        // pulse length follows clocks per microsecond, completion masked
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h3);
        ofc_cpu_model_inst.wr(`OFC_REG_IMASK, 32'h2);
        for (int u = 1; u <= 3; u += 2) begin
            ofc_cpu_model_inst.wr(`OFC_REG_USEC, 32'(u));
            @(negedge ref_clk);
            b0 = busyLen;
            ofc_cpu_model_inst.op(`OFC_CMD_PROG, 16'(4 + 4 * u), 32'h0);
            ofc_cpu_model_inst.wait_idle(s);
            b0 = busyLen - b0;
            chk(32'(b0 >= `OFC_PROG_USEC * u && b0 <= `OFC_PROG_USEC * u + 3), 32'h1);
        end
        rdchk(`OFC_REG_RIS, 32'h1);
        rdchk(`OFC_REG_MIS, 32'h0);
        chk({31'h0, flashIrq}, 32'h0);
        ofc_cpu_model_inst.wr(`OFC_REG_IMASK, 32'h1);
        rdchk(`OFC_REG_MIS, 32'h1);
        chk({31'h0, flashIrq}, 32'h1);
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h1);
        rdchk(`OFC_REG_RIS, 32'h0);
        // unit 1 read-only, unit 2 execute-only
        ofc_cpu_model_inst.wr(`OFC_REG_IMASK, 32'h2);
        ofc_cpu_model_inst.wr(`OFC_REG_PROT, 32'h0000_0024);
        rdchk(`OFC_REG_PROT, 32'h0000_0024);
        ofc_cpu_model_inst.op(`OFC_CMD_PROG, 16'h0800, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        chk(s & 32'h2, 32'h2);
        rdchk(`OFC_REG_RIS, 32'h2);
        chk({31'h0, flashIrq}, 32'h1);
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.op(`OFC_CMD_ERASE, 16'h0c00, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        chk(s & 32'h2, 32'h2);
        ofc_cpu_model_inst.op(`OFC_CMD_ERASE, 16'h0800, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        rdchk(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.peek(16'h0800, v);
        chk(v, `OFC_ERASED_WORD);
        rdchk(`OFC_REG_RIS, 32'h0);
        ofc_cpu_model_inst.op(`OFC_CMD_PROG, 16'h1000, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        chk(s & 32'h2, 32'h2);
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.wr(`OFC_REG_ACCESS, {14'h0, 16'h1000, 2'b01});
        rdchk(`OFC_REG_RIS, 32'h0);
        ofc_cpu_model_inst.wr(`OFC_REG_ACCESS, {14'h0, 16'h1000, 2'b10});
        rdchk(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.wr(`OFC_REG_RIS, 32'h2);
        ofc_cpu_model_inst.peek(16'h1000, v);
        chk(v, 32'h0);
        rdchk(`OFC_REG_RIS, 32'h2);
        // loosening and code 3 refused per field
        ofc_cpu_model_inst.wr(`OFC_REG_PROT, 32'h0000_0000);
        rdchk(`OFC_REG_PROT, 32'h0000_0024);
        ofc_cpu_model_inst.wr(`OFC_REG_PROT, 32'h0000_0018);
        rdchk(`OFC_REG_PROT, 32'h0000_0028);
        ofc_cpu_model_inst.wr(`OFC_REG_PROT, 32'h0000_003b);
        rdchk(`OFC_REG_PROT, 32'h0000_0028);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        resetChk();
        ofc_cpu_model_inst.op(`OFC_CMD_SAVE, 16'h0000, 32'h0);
        ofc_cpu_model_inst.wait_idle(s);
        rdchk(`OFC_REG_STAT, 32'h4);
        finalReport();
    end
endmodule

// ---- hdl/ofc_usec_timer.sv ----
// Purpose: counts whole microseconds from a clocks-per-microsecond value
// Assumes: clocksPerUsec at least one
// Notes:   done pulses one cycle when the requested count has elapsed
`include "ofc_consts.svh"
module ofc_usec_timer (
    input  wire logic        ref_clk,       // system clock
    input  wire logic        reset_n,       // async reset, active low
    input  wire logic        start,         // load and run
    input  wire logic [15:0] usecCount,     // microseconds to time
    input  wire logic [7:0]  clocksPerUsec, // clocks in one microsecond
    output logic             running,       // timer active
    output logic             done           // one-cycle end pulse
);
    logic [7:0]  clkCnt_r, clkCnt_nxt;
    logic [15:0] usCnt_r, usCnt_nxt;
    logic        run_r, run_nxt;
    logic        done_r, done_nxt;

    always_comb begin
        clkCnt_nxt = clkCnt_r;
        usCnt_nxt  = usCnt_r;
        run_nxt    = run_r;
        done_nxt   = 1'b0;
        if (start) begin
            clkCnt_nxt = 8'h01;
            usCnt_nxt  = usecCount;
            run_nxt    = 1'b1;
        end else if (run_r) begin
            if (clkCnt_r >= clocksPerUsec) begin
                clkCnt_nxt = 8'h01;
                if (usCnt_r <= 16'h0001) begin
                    run_nxt  = 1'b0;
                    done_nxt = 1'b1;
                end else begin
                    usCnt_nxt = usCnt_r - 16'h0001;
                end
            end else begin
                clkCnt_nxt = clkCnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkCnt_r <= 8'h00;
            usCnt_r  <= 16'h0000;
            run_r    <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            clkCnt_r <= clkCnt_nxt;
            usCnt_r  <= usCnt_nxt;
            run_r    <= run_nxt;
            done_r   <= done_nxt;
        end
    end

    assign running = run_r;
    assign done    = done_r;
endmodule

// ---- hdl/onchip_flash_controller.sv ----
// Purpose: flash sequencer with erase, word program, protection and interrupts
// Assumes: single 200 MHz clock; register port with read data one cycle later
// Notes:   the array is modelled as a small word memory inside the block
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "ofc_consts.svh"
module onchip_flash_controller
    import ofc_pkg::*;
(
    input  wire logic        ref_clk,   // system clock
    input  wire logic        reset_n,   // async reset, active low
    input  wire logic [7:0]  regAddr,   // register byte address
    input  wire logic [31:0] regWdata,  // register write data
    input  wire logic        regWr,     // write strobe
    input  wire logic        regRd,     // read strobe
    output logic      [31:0] regRdata,  // read data, cycle after strobe
    output logic             flashIrq,  // level interrupt
    output logic             busy       // operation in progress
);
    localparam int NWORDS = `OFC_NUM_EBLK * 256;
    localparam logic [15:0] PROG_US  = 16'(`OFC_PROG_USEC);
    localparam logic [15:0] ERASE_US = 16'(`OFC_ERASE_USEC);

    logic [31:0] memArr [NWORDS];

    ofc_state_t  state_r, state_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    logic [1:0]  op_r, op_nxt;
    logic [7:0]  usec_r, usec_nxt;
    logic [1:0]  ris_r, ris_nxt;
    logic [1:0]  imask_r, imask_nxt;
    logic        fail_r, fail_nxt;
    logic        saved_r, saved_nxt;
    logic [1:0]  prot_r [`OFC_NUM_PUNIT];
    logic [1:0]  prot_nxt [`OFC_NUM_PUNIT];
    logic [31:0] rdata_r, rdata_nxt;
    logic        irq_r, irq_nxt;
    logic        busy_r, busy_nxt;
    logic        tmrStart;
    logic [15:0] tmrUs;
    logic        tmrDone;
    logic        eraseStep_r, eraseStep_nxt;
    logic [7:0]  eraseIdx_r, eraseIdx_nxt;

    function automatic logic [1:0] unitOf(input logic [15:0] a);
        unitOf = a[`OFC_PUNIT_SHIFT+1:`OFC_PUNIT_SHIFT];
    endfunction

    function automatic logic [10:0] wordOf(input logic [15:0] a);
        wordOf = a[`OFC_BLK_MSB:`OFC_WORD_LSB];
    endfunction

    function automatic logic stricter(input logic [1:0] cur, input logic [1:0] req);
        stricter = (cur == prot_read_write && req != prot_read_write) ||
                   (cur == prot_read_only  && req == prot_exec_only)  ||
                   (cur == req);
    endfunction

    ofc_usec_timer u_timer (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .start         (tmrStart),
        .usecCount     (tmrUs),
        .clocksPerUsec (usec_r),
        .running       (),
        .done          (tmrDone)
    );

    logic        cmdWr, accWr;
    logic [1:0]  cmdUnit;
    logic        cmdProt;
    logic [1:0]  accUnit;
    logic        accBad;

    always_comb begin
        cmdWr   = regWr && regAddr == `OFC_REG_CMD;
        accWr   = regWr && regAddr == `OFC_REG_ACCESS;
        cmdUnit = unitOf(addr_r);
        cmdProt = prot_r[cmdUnit] != prot_read_write;
        accUnit = unitOf(regWdata[`OFC_FADDR_W+`OFC_ACC_START-1:`OFC_ACC_START]);
        // data or debug reads of an execute-only unit are refused
        accBad  = (accWr && !regWdata[`OFC_ACC_FETCH] &&
                   prot_r[accUnit] == prot_exec_only) ||
                  (regRd && regAddr == `OFC_REG_DATA &&
                   prot_r[cmdUnit] == prot_exec_only);
    end

    // command sequencer
    always_comb begin
        state_nxt     = state_r;
        addr_nxt      = addr_r;
        data_nxt      = data_r;
        op_nxt        = op_r;
        fail_nxt      = fail_r;
        saved_nxt     = saved_r;
        tmrStart      = 1'b0;
        tmrUs         = PROG_US;
        eraseStep_nxt = 1'b0;
        eraseIdx_nxt  = eraseIdx_r;
        if (regWr && regAddr == `OFC_REG_ADDR && state_r == ST_IDLE) begin
            addr_nxt = {regWdata[15:2], 2'b00};
        end
        if (regWr && regAddr == `OFC_REG_DATA && state_r == ST_IDLE) begin
            data_nxt = regWdata;
        end
        case (state_r)
            ST_IDLE: begin
                if (cmdWr) begin
                    op_nxt = regWdata[1:0];
                    if (regWdata[1:0] == `OFC_CMD_SAVE) begin
                        saved_nxt = 1'b1;
                        fail_nxt  = 1'b0;
                    end else if (regWdata[1:0] == `OFC_CMD_PROG ||
                                 regWdata[1:0] == `OFC_CMD_ERASE) begin
                        if (cmdProt) begin
                            fail_nxt = 1'b1;
                        end else begin
                            fail_nxt  = 1'b0;
                            tmrStart  = 1'b1;
                            tmrUs     = (regWdata[1:0] == `OFC_CMD_ERASE) ? ERASE_US
                                                                         : PROG_US;
                            state_nxt = ST_PULSE;
                        end
                    end
                end
            end
            ST_PULSE: begin
                if (tmrDone) begin
                    state_nxt    = ST_DONE;
                    eraseIdx_nxt = 8'h00;
                end
            end
            ST_DONE: begin
                if (op_r == `OFC_CMD_ERASE) begin
                    eraseStep_nxt = 1'b1;
                    eraseIdx_nxt  = eraseIdx_r + 8'h01;
                    if (eraseIdx_r == 8'hff) begin
                        state_nxt = ST_IDLE;
                    end
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    logic [10:0] progWord, eraseWord;
    logic        opFinish;
    assign progWord  = wordOf(addr_r);
    assign eraseWord = {addr_r[`OFC_BLK_MSB:`OFC_EBLK_SHIFT], eraseIdx_r};
    assign opFinish  = state_r == ST_DONE &&
                       (op_r != `OFC_CMD_ERASE || eraseIdx_r == 8'hff);

    always_ff @(posedge ref_clk) begin
        if (state_r == ST_DONE && op_r == `OFC_CMD_PROG) begin
            memArr[progWord] <= memArr[progWord] & data_r;
        end
        if (state_r == ST_DONE && op_r == `OFC_CMD_ERASE) begin
            memArr[eraseWord] <= `OFC_ERASED_WORD;
        end
    end

    // protection, interrupts and configuration
    always_comb begin
        usec_nxt  = usec_r;
        imask_nxt = imask_r;
        ris_nxt   = ris_r;
        for (int i = 0; i < `OFC_NUM_PUNIT; i++) begin
            prot_nxt[i] = prot_r[i];
        end
        if (regWr && regAddr == `OFC_REG_USEC) begin
            usec_nxt = regWdata[7:0];
        end
        if (regWr && regAddr == `OFC_REG_IMASK) begin
            imask_nxt = regWdata[1:0];
        end
        if (regWr && regAddr == `OFC_REG_PROT) begin
            for (int i = 0; i < `OFC_NUM_PUNIT; i++) begin
                if (stricter(prot_r[i], regWdata[2*i+:2]) &&
                    regWdata[2*i+:2] != 2'b11) begin
                    prot_nxt[i] = regWdata[2*i+:2];
                end
            end
        end
        if (regWr && regAddr == `OFC_REG_RIS) begin
            ris_nxt = ris_r & ~regWdata[1:0];
        end
        if (opFinish) begin
            ris_nxt[`OFC_IRQ_PROG] = 1'b1;
        end
        if (accBad || (cmdWr && state_r == ST_IDLE && cmdProt &&
            (regWdata[1:0] == `OFC_CMD_PROG || regWdata[1:0] == `OFC_CMD_ERASE))) begin
            ris_nxt[`OFC_IRQ_ACCESS] = 1'b1;
        end
        irq_nxt  = |(ris_nxt & imask_nxt);
        busy_nxt = state_nxt != ST_IDLE;
    end

    // register read port
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                `OFC_REG_ADDR:  rdata_nxt = {16'h0000, addr_r};
                `OFC_REG_DATA:  rdata_nxt = memArr[wordOf(addr_r)] &
                                 {32{prot_r[cmdUnit] != prot_exec_only}};
                `OFC_REG_CMD:   rdata_nxt = {30'h0, op_r};
                `OFC_REG_STAT:  rdata_nxt = {29'h0, saved_r, fail_r, busy_r};
                `OFC_REG_USEC:  rdata_nxt = {24'h0, usec_r};
                `OFC_REG_RIS:   rdata_nxt = {30'h0, ris_r};
                `OFC_REG_IMASK: rdata_nxt = {30'h0, imask_r};
                `OFC_REG_MIS:   rdata_nxt = {30'h0, ris_r & imask_r};
                `OFC_REG_PROT:  rdata_nxt = {24'h0, prot_r[3], prot_r[2],
                                             prot_r[1], prot_r[0]};
                default:        rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= ST_IDLE;
            addr_r      <= 16'h0000;
            data_r      <= 32'hffff_ffff;
            op_r        <= 2'h0;
            usec_r      <= `OFC_USEC_RESET;
            ris_r       <= 2'h0;
            imask_r     <= 2'h0;
            fail_r      <= 1'b0;
            saved_r     <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            irq_r       <= 1'b0;
            busy_r      <= 1'b0;
            eraseStep_r <= 1'b0;
            eraseIdx_r  <= 8'h00;
            for (int i = 0; i < `OFC_NUM_PUNIT; i++) begin
                prot_r[i] <= prot_read_write;
            end
        end else begin
            state_r     <= state_nxt;
            addr_r      <= addr_nxt;
            data_r      <= data_nxt;
            op_r        <= op_nxt;
            usec_r      <= usec_nxt;
            ris_r       <= ris_nxt;
            imask_r     <= imask_nxt;
            fail_r      <= fail_nxt;
            saved_r     <= saved_nxt;
            rdata_r     <= rdata_nxt;
            irq_r       <= irq_nxt;
            busy_r      <= busy_nxt;
            eraseStep_r <= eraseStep_nxt;
            eraseIdx_r  <= eraseIdx_nxt;
            for (int i = 0; i < `OFC_NUM_PUNIT; i++) begin
                prot_r[i] <= prot_nxt[i];
            end
        end
    end

    assign regRdata = rdata_r;
    assign flashIrq = irq_r;
    assign busy     = busy_r;

    sequence protCmd_s;
        cmdWr && state_r == ST_IDLE && cmdProt &&
        (regWdata[1:0] == `OFC_CMD_PROG || regWdata[1:0] == `OFC_CMD_ERASE);
    endsequence

    prot_refuse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        protCmd_s |=> state_r == ST_IDLE && fail_r && !busy)
        else $error("protected command was started");
    viol_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (protCmd_s or accBad) |=> ris_r[`OFC_IRQ_ACCESS])
        else $error("violation flag not set");
    done_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        opFinish |=> ris_r[`OFC_IRQ_PROG])
        else $error("completion flag not set");
    irq_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        flashIrq == |(ris_r & imask_r))
        else $error("interrupt line not gated by enables");
    no_loosen_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        prot_r[2] == prot_exec_only |=> prot_r[2] == prot_exec_only)
        else $error("execute-only unit loosened");
    prog_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == ST_DONE && op_r == `OFC_CMD_PROG |=>
        (memArr[$past(progWord)] & ~$past(memArr[progWord])) == 32'h0)
        else $error("program set a bit");
    busy_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == ST_PULSE |=> busy)
        else $error("busy low during pulse");
    clear_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWr && regAddr == `OFC_REG_RIS && regWdata[0] && !opFinish |=>
        !ris_r[`OFC_IRQ_PROG])
        else $error("flag not cleared");

    // commands arriving mid-operation must leave the sequencer alone
    sequence cmdBusy_s;
        cmdWr && state_r != ST_IDLE;
    endsequence

    // last word of the erase walk
    sequence eraseEnd_s;
        state_r == ST_DONE && op_r == `OFC_CMD_ERASE && eraseIdx_r == 8'hff;
    endsequence

    busy_refuse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmdBusy_s |=> op_r == $past(op_r))
        else $error("command taken while busy");
    erase_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        eraseEnd_s |=> state_r == ST_IDLE && !busy)
        else $error("erase did not finish");
    erase_fill_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        eraseStep_r |-> memArr[$past(eraseWord)] == `OFC_ERASED_WORD)
        else $error("erased word not all ones");
    pulse_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        tmrStart |=> state_r == ST_PULSE && busy)
        else $error("timed pulse not started");
    exec_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regRd && regAddr == `OFC_REG_DATA && prot_r[cmdUnit] == prot_exec_only |=>
        regRdata == 32'h0000_0000)
        else $error("execute-only word readable");
    mis_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regRd && regAddr == `OFC_REG_MIS |=> regRdata[1:0] == $past(ris_r & imask_r))
        else $error("masked flags read wrong");
    save_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmdWr && state_r == ST_IDLE && regWdata[1:0] == `OFC_CMD_SAVE |=> saved_r)
        else $error("save not recorded");
endmodule

// ---- pkg/ofc_consts.svh ----
// Purpose: constants for the on-chip flash controller
// Assumes: 200 MHz ref_clk, 32-bit register port
// Notes:   offsets are byte addresses of 32-bit words
`ifndef OFC_CONSTS_SVH
`define OFC_CONSTS_SVH

`define OFC_ADDR_W        8
`define OFC_FADDR_W       16
`define OFC_NUM_EBLK      8
`define OFC_NUM_PUNIT     4
`define OFC_EBLK_SHIFT    10
`define OFC_PUNIT_SHIFT   11
`define OFC_WORD_MSB      9
`define OFC_WORD_LSB      2
`define OFC_BLK_MSB       12
`define OFC_PUNIT_MSB     12
`define OFC_ERASED_WORD   32'hffff_ffff

`define OFC_REG_ADDR      8'h00
`define OFC_REG_DATA      8'h04
`define OFC_REG_CMD       8'h08
`define OFC_REG_STAT      8'h0c
`define OFC_REG_USEC      8'h10
`define OFC_REG_RIS       8'h14
`define OFC_REG_IMASK     8'h18
`define OFC_REG_MIS       8'h1c
`define OFC_REG_PROT      8'h20
`define OFC_REG_ACCESS    8'h24

`define OFC_CMD_PROG      2'h1
`define OFC_CMD_ERASE     2'h2
`define OFC_CMD_SAVE      2'h3

`define OFC_IRQ_PROG      0
`define OFC_IRQ_ACCESS    1

`define OFC_STAT_BUSY     0
`define OFC_STAT_FAIL     1
`define OFC_STAT_SAVED    2

`define OFC_PROG_USEC     20
`define OFC_ERASE_USEC    2000
`define OFC_USEC_RESET    8'hc8

`define OFC_ACC_FETCH     0
`define OFC_ACC_DEBUG     1
`define OFC_ACC_START     2

`endif

// ---- pkg/ofc_pkg.sv ----
// Purpose: shared types for the on-chip flash controller
// Assumes: used with ofc_consts.svh
// Notes:   protection codes only grow between resets
package ofc_pkg;
    typedef enum logic [1:0] {
        prot_read_write = 2'b00,
        prot_read_only  = 2'b01,
        prot_exec_only  = 2'b10
    } ofc_prot_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PULSE = 2'b01,
        ST_DONE  = 2'b10
    } ofc_state_t;
endpackage
